// ### hw/mbdsc_backoff.sv
// collision back-off engine: lfsr, exponent select and slot-time countdown
// assumes collision is a one-cycle pulse and slot_cycles is at least one
module mbdsc_backoff (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   mbdsc_bo_if.engine bo
);

   mbdsc_pkg::mbdsc_bo_state_t state_ff, nxt_state;
   logic [15:0] lfsr_ff, nxt_lfsr;
   logic [9:0] cnt_ff, nxt_cnt;
   logic [11:0] slot_ff, nxt_slot;
   logic busy_ff, nxt_busy;
   logic done_ff, nxt_done;

   // =====================================================================
   // next state
   always_comb begin
      logic [4:0] cap;
      logic [4:0] nbits;
      logic [9:0] mask;
      cap = mbdsc_pkg::CAP_ONE;
      nbits = 5'h0;
      mask = 10'h0;
      nxt_lfsr = lfsr_ff[0] ? ((lfsr_ff >> 1) ^ mbdsc_pkg::LFSR_TAPS) : (lfsr_ff >> 1);
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_slot = slot_ff;
      case (bo.limit)
         mbdsc_pkg::LIMIT_TEN: cap = mbdsc_pkg::CAP_TEN;
         mbdsc_pkg::LIMIT_EIGHT: cap = mbdsc_pkg::CAP_EIGHT;
         mbdsc_pkg::LIMIT_FOUR: cap = mbdsc_pkg::CAP_FOUR;
         default: cap = mbdsc_pkg::CAP_ONE;
      endcase
      nbits = mbdsc_pkg::mbdsc_min5(mbdsc_pkg::mbdsc_min5(bo.retry_count, mbdsc_pkg::MAX_EXPONENT), cap);
      mask = 10'((11'h1 << nbits) - 11'h1);
      if (bo.flush) begin
         nxt_state = mbdsc_pkg::MBDSC_BO_IDLE;
         nxt_cnt = 10'h0;
         nxt_slot = 12'h0;
      end else if (bo.collision) begin
         nxt_cnt = lfsr_ff[9:0] & mask;
         nxt_slot = 12'h0;
         nxt_state = ((lfsr_ff[9:0] & mask) == 10'h0) ? mbdsc_pkg::MBDSC_BO_DONE : mbdsc_pkg::MBDSC_BO_COUNT;
      end else begin
         case (state_ff)
            mbdsc_pkg::MBDSC_BO_IDLE: nxt_state = mbdsc_pkg::MBDSC_BO_IDLE;
            mbdsc_pkg::MBDSC_BO_COUNT: begin
               if (slot_ff >= bo.slot_cycles - 12'h1) begin
                  nxt_slot = 12'h0;
                  nxt_cnt = cnt_ff - 10'h1;
                  if (cnt_ff == 10'h1) begin
                     nxt_state = mbdsc_pkg::MBDSC_BO_DONE;
                  end
               end else begin
                  nxt_slot = slot_ff + 12'h1;
               end
            end
            mbdsc_pkg::MBDSC_BO_DONE: nxt_state = mbdsc_pkg::MBDSC_BO_IDLE;
            default: nxt_state = mbdsc_pkg::MBDSC_BO_IDLE;
         endcase
      end
      nxt_busy = (nxt_state == mbdsc_pkg::MBDSC_BO_COUNT);
      nxt_done = (nxt_state == mbdsc_pkg::MBDSC_BO_DONE);
   end

   // =====================================================================
   // registers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= mbdsc_pkg::MBDSC_BO_IDLE;
         lfsr_ff <= mbdsc_pkg::LFSR_SEED;
         cnt_ff <= 10'h0;
         slot_ff <= 12'h0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         lfsr_ff <= nxt_lfsr;
         cnt_ff <= nxt_cnt;
         slot_ff <= nxt_slot;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
      end
   end

   assign bo.busy = busy_ff;
   assign bo.done = done_ff;

endmodule

// ### hw/mbdsc_bo_if.sv
// signals between the control top and the back-off engine
// assumes both ends run on the same clock
interface mbdsc_bo_if;
   logic collision;
   logic [4:0] retry_count;
   logic [1:0] limit;
   logic [11:0] slot_cycles;
   logic flush;
   logic busy;
   logic done;

   modport ctrl (output collision, retry_count, limit, slot_cycles, flush, input busy, done);
   modport engine (input collision, retry_count, limit, slot_cycles, flush, output busy, done);
endinterface

// ### hw/mbdsc_ctrl.sv
// top of the mac back-off, duplex and speed control block
// assumes all inputs synchronous to i_ref_clk; i_rxc_div is the receive clock
// divided by 64 upstream; strobes are one-cycle pulses
module mbdsc_ctrl (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_cfg_write,
   input wire logic i_wr_duplex_select,
   input wire logic [1:0] i_wr_speed_select,
   input wire logic i_wr_auto_duplex_detect,
   input wire logic i_wr_auto_speed_detect,
   input wire logic [1:0] i_wr_backoff_limit_select,
   input wire logic i_wr_mac_soft_reset,
   input wire logic i_image_load,
   input wire logic i_eeprom_present,
   input wire logic [4:0] i_eeprom_image,
   input wire logic i_otp_programmed,
   input wire logic [4:0] i_otp_image,
   input wire logic i_usb_reset,
   input wire logic i_light_soft_reset,
   input wire logic i_reset_protect,
   input wire logic i_rxc_div,
   input wire logic i_inband_valid,
   input wire logic i_inband_full_duplex,
   input wire logic i_collision,
   input wire logic [4:0] i_retry_count,
   output logic o_duplex_select,
   output logic [1:0] o_speed_select,
   output logic o_auto_duplex_detect,
   output logic o_auto_speed_detect,
   output logic [1:0] o_backoff_limit_select,
   output logic o_mac_soft_reset,
   output logic o_full_duplex,
   output logic o_backoff_busy,
   output logic o_backoff_done
);

   mbdsc_bo_if bo ();

   logic rxc_prev_ff, nxt_rxc_prev;
   logic [10:0] period_ff, nxt_period;
   logic [1:0] det_speed_ff, nxt_det_speed;
   logic det_duplex_ff, nxt_det_duplex;

   logic [4:0] image_ff, nxt_image;
   logic duplex_ff, nxt_duplex;
   logic [1:0] speed_ff, nxt_speed;
   logic auto_duplex_ff, nxt_auto_duplex;
   logic auto_speed_ff, nxt_auto_speed;
   logic [1:0] limit_ff, nxt_limit;
   logic full_duplex_ff, nxt_full_duplex;

   logic mac_soft_reset_ff, nxt_mac_soft_reset;
   logic [3:0] mac_soft_reset_cnt_ff, nxt_mac_soft_reset_cnt;

   // =====================================================================
   // link speed and duplex detection
   always_comb begin
      nxt_rxc_prev = i_rxc_div;
      nxt_period = period_ff;
      nxt_det_speed = det_speed_ff;
      nxt_det_duplex = det_duplex_ff;
      if (i_rxc_div && !rxc_prev_ff) begin
         nxt_period = 11'h0;
         if (period_ff >= mbdsc_pkg::RXC_THR_10) begin
            nxt_det_speed = mbdsc_pkg::SPEED_10;
         end else if (period_ff >= mbdsc_pkg::RXC_THR_100) begin
            nxt_det_speed = mbdsc_pkg::SPEED_100;
         end else begin
            nxt_det_speed = mbdsc_pkg::SPEED_1000;
         end
      end else if (period_ff != mbdsc_pkg::RXC_PERIOD_MAX) begin
         nxt_period = period_ff + 11'h1;
      end
      if (i_inband_valid) begin
         nxt_det_duplex = i_inband_full_duplex;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rxc_prev_ff <= 1'b0;
         period_ff <= 11'h0;
         det_speed_ff <= mbdsc_pkg::RST_SPEED;
         det_duplex_ff <= mbdsc_pkg::RST_DUPLEX;
      end else begin
         rxc_prev_ff <= nxt_rxc_prev;
         period_ff <= nxt_period;
         det_speed_ff <= nxt_det_speed;
         det_duplex_ff <= nxt_det_duplex;
      end
   end

   // =====================================================================
   // configuration fields
   // priority: image load, then usb or light reset, then software write
   always_comb begin
      logic restore;
      restore = i_usb_reset | i_light_soft_reset;
      nxt_image = image_ff;
      nxt_duplex = duplex_ff;
      nxt_speed = speed_ff;
      nxt_auto_duplex = auto_duplex_ff;
      nxt_auto_speed = auto_speed_ff;
      nxt_limit = limit_ff;
      if (i_image_load) begin
         if (i_eeprom_present) begin
            nxt_image = i_eeprom_image;
         end else if (i_otp_programmed) begin
            nxt_image = i_otp_image;
         end else begin
            nxt_image = mbdsc_pkg::IMG_DEFAULT;
         end
         nxt_duplex = nxt_image[mbdsc_pkg::IMG_DUPLEX];
         nxt_speed = nxt_image[mbdsc_pkg::IMG_SPEED_LO +: 2];
         nxt_auto_duplex = nxt_image[mbdsc_pkg::IMG_AUTO_DUPLEX];
         nxt_auto_speed = nxt_image[mbdsc_pkg::IMG_AUTO_SPEED];
      end else if (restore) begin
         if (!i_reset_protect) begin
            nxt_duplex = image_ff[mbdsc_pkg::IMG_DUPLEX];
            nxt_speed = image_ff[mbdsc_pkg::IMG_SPEED_LO +: 2];
         end
         nxt_auto_duplex = image_ff[mbdsc_pkg::IMG_AUTO_DUPLEX];
         nxt_auto_speed = image_ff[mbdsc_pkg::IMG_AUTO_SPEED];
         nxt_limit = mbdsc_pkg::RST_LIMIT;
      end else if (i_cfg_write) begin
         nxt_limit = i_wr_backoff_limit_select;
         nxt_auto_duplex = i_wr_auto_duplex_detect;
         nxt_auto_speed = i_wr_auto_speed_detect;
         if (!auto_duplex_ff) begin
            nxt_duplex = i_wr_duplex_select;
         end
         if (!auto_speed_ff) begin
            nxt_speed = i_wr_speed_select;
         end
      end
      // outside an image load, auto modes overwrite the field with what the link reports
      if (nxt_auto_duplex && !i_image_load) begin
         nxt_duplex = det_duplex_ff;
      end
      if (nxt_auto_speed && !i_image_load) begin
         nxt_speed = det_speed_ff;
      end
      nxt_full_duplex = nxt_duplex | (nxt_speed >= mbdsc_pkg::SPEED_1000);
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         image_ff <= mbdsc_pkg::IMG_DEFAULT;
         duplex_ff <= mbdsc_pkg::RST_DUPLEX;
         speed_ff <= mbdsc_pkg::RST_SPEED;
         auto_duplex_ff <= mbdsc_pkg::RST_AUTO_DUPLEX;
         auto_speed_ff <= mbdsc_pkg::RST_AUTO_SPEED;
         limit_ff <= mbdsc_pkg::RST_LIMIT;
         full_duplex_ff <= mbdsc_pkg::RST_DUPLEX;
      end else begin
         image_ff <= nxt_image;
         duplex_ff <= nxt_duplex;
         speed_ff <= nxt_speed;
         auto_duplex_ff <= nxt_auto_duplex;
         auto_speed_ff <= nxt_auto_speed;
         limit_ff <= nxt_limit;
         full_duplex_ff <= nxt_full_duplex;
      end
   end

   // =====================================================================
   // self-clearing mac reset
   always_comb begin
      nxt_mac_soft_reset = mac_soft_reset_ff;
      nxt_mac_soft_reset_cnt = mac_soft_reset_cnt_ff;
      if (mac_soft_reset_ff) begin
         nxt_mac_soft_reset_cnt = mac_soft_reset_cnt_ff + 4'h1;
         if (mac_soft_reset_cnt_ff == mbdsc_pkg::MAC_RST_CYCLES - 4'h1) begin
            nxt_mac_soft_reset = 1'b0;
            nxt_mac_soft_reset_cnt = 4'h0;
         end
      end else if (i_cfg_write && i_wr_mac_soft_reset) begin
         nxt_mac_soft_reset = 1'b1;
         nxt_mac_soft_reset_cnt = 4'h0;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         mac_soft_reset_ff <= 1'b0;
         mac_soft_reset_cnt_ff <= 4'h0;
      end else begin
         mac_soft_reset_ff <= nxt_mac_soft_reset;
         mac_soft_reset_cnt_ff <= nxt_mac_soft_reset_cnt;
      end
   end

   // =====================================================================
   // back-off engine
   assign bo.collision = i_collision & ~mac_soft_reset_ff;
   assign bo.retry_count = i_retry_count;
   assign bo.limit = limit_ff;
   assign bo.slot_cycles = mbdsc_pkg::mbdsc_slot_cycles(speed_ff);
   assign bo.flush = mac_soft_reset_ff;

   mbdsc_backoff u_backoff (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .bo(bo)
   );

   // =====================================================================
   // outputs
   assign o_duplex_select = duplex_ff;
   assign o_speed_select = speed_ff;
   assign o_auto_duplex_detect = auto_duplex_ff;
   assign o_auto_speed_detect = auto_speed_ff;
   assign o_backoff_limit_select = limit_ff;
   assign o_mac_soft_reset = mac_soft_reset_ff;
   assign o_full_duplex = full_duplex_ff;
   assign o_backoff_busy = bo.busy;
   assign o_backoff_done = bo.done;

endmodule

// ### hw/mbdsc_pkg.sv
// constants, types and helpers of the mac back-off, duplex and speed control block
// assumes one 40 mhz clock and an asynchronous active-high reset
package mbdsc_pkg;

   // =====================================================================
   // back-off state machine
   typedef enum logic [1:0] {
      MBDSC_BO_IDLE  = 2'h0,
      MBDSC_BO_COUNT = 2'h1,
      MBDSC_BO_DONE  = 2'h3
   } mbdsc_bo_state_t;

   // =====================================================================
   // speed codes and limit codes
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic [1:0] LIMIT_TEN = 2'h0;
   localparam logic [1:0] LIMIT_EIGHT = 2'h1;
   localparam logic [1:0] LIMIT_FOUR = 2'h2;
   localparam logic [4:0] MAX_EXPONENT = 5'hA;
   localparam logic [4:0] CAP_TEN = 5'hA;
   localparam logic [4:0] CAP_EIGHT = 5'h8;
   localparam logic [4:0] CAP_FOUR = 5'h4;
   localparam logic [4:0] CAP_ONE = 5'h1;

   // =====================================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned SLOT_BIT_TIMES = 512;
   localparam int unsigned BIT_NS_10 = 100;
   localparam int unsigned BIT_NS_100 = 10;
   localparam int unsigned BIT_NS_1000 = 1;
   localparam int unsigned SLOT_NS_10 = SLOT_BIT_TIMES * BIT_NS_10;
   localparam int unsigned SLOT_NS_100 = SLOT_BIT_TIMES * BIT_NS_100;
   localparam int unsigned SLOT_NS_1000 = SLOT_BIT_TIMES * BIT_NS_1000;
   localparam logic [11:0] SLOT_CYC_10 = 12'((SLOT_NS_10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] SLOT_CYC_100 = 12'((SLOT_NS_100 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] SLOT_CYC_1000 = 12'((SLOT_NS_1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] MAC_RST_CYCLES = 4'hF;

   // =====================================================================
   // lfsr
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS = 16'hB400;

   // =====================================================================
   // receive clock period thresholds, in clock cycles from one rising edge of the divided rxc to the next
   localparam logic [10:0] RXC_PERIOD_MAX = 11'h7FF;
   localparam logic [10:0] RXC_THR_10 = 11'h200;
   localparam logic [10:0] RXC_THR_100 = 11'h032;

   // =====================================================================
   // boot image layout and reset values
   localparam int unsigned IMG_DUPLEX = 0;
   localparam int unsigned IMG_SPEED_LO = 1;
   localparam int unsigned IMG_AUTO_DUPLEX = 3;
   localparam int unsigned IMG_AUTO_SPEED = 4;
   localparam logic [4:0] IMG_DEFAULT = 5'h08;
   localparam logic RST_DUPLEX = 1'b0;
   localparam logic [1:0] RST_SPEED = 2'h0;
   localparam logic RST_AUTO_DUPLEX = 1'b1;
   localparam logic RST_AUTO_SPEED = 1'b0;
   localparam logic [1:0] RST_LIMIT = 2'h0;

   function automatic logic [4:0] mbdsc_min5(input logic [4:0] a, input logic [4:0] b);
      mbdsc_min5 = (a < b) ? a : b;
   endfunction

   function automatic logic [11:0] mbdsc_slot_cycles(input logic [1:0] speed);
      case (speed)
         SPEED_10: mbdsc_slot_cycles = SLOT_CYC_10;
         SPEED_100: mbdsc_slot_cycles = SLOT_CYC_100;
         default: mbdsc_slot_cycles = SLOT_CYC_1000;
      endcase
   endfunction

endpackage

// ### tb/mbdsc_monitor.sv
// port checks of the back-off, duplex and speed control top
// assumes one clock domain with async active-high reset; bound from the bench
module mbdsc_monitor (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_cfg_write,
   input wire logic [1:0] i_wr_backoff_limit_select,
   input wire logic i_wr_mac_soft_reset,
   input wire logic i_image_load,
   input wire logic i_usb_reset,
   input wire logic i_light_soft_reset,
   input wire logic i_collision,
   input wire logic [4:0] i_retry_count,
   input wire logic o_duplex_select,
   input wire logic [1:0] o_speed_select,
   input wire logic [1:0] o_backoff_limit_select,
   input wire logic o_mac_soft_reset,
   input wire logic o_full_duplex,
   input wire logic o_backoff_busy,
   input wire logic o_backoff_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_ok;
   logic [3:0] mcnt_ff;
   logic [21:0] bcnt_ff;
   int unsigned slot;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   assign wr_ok = i_cfg_write && !i_image_load && !i_usb_reset && !i_light_soft_reset;
   always_comb slot = (o_speed_select == 2'h0) ? 2048 : (o_speed_select == 2'h1) ? 205 : 21;
   // ==========
   // mac reset length and busy length since the last collision
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         mcnt_ff <= 4'h0;
         bcnt_ff <= 22'h0;
      end else begin
         mcnt_ff <= o_mac_soft_reset ? mcnt_ff + 4'h1 : 4'h0;
         // counts every cycle that busy stood, from the first one after the collision
         bcnt_ff <= (i_collision || !o_backoff_busy) ? 22'h0 : bcnt_ff + 22'h1;
      end
   end
   // ==========
   // assertions
   chk_full_duplex_gig: assert property (o_full_duplex == (o_duplex_select || o_speed_select[1]))
      else $error("full duplex flag wrong");
   chk_mac_soft_reset_start: assert property (wr_ok && i_wr_mac_soft_reset && !o_mac_soft_reset |=> o_mac_soft_reset)
      else $error("mac reset did not start");
   chk_mac_soft_reset_length: assert property ($fell(o_mac_soft_reset) |-> mcnt_ff == 4'hF)
      else $error("mac reset length wrong");
   chk_mac_soft_reset_bound: assert property (o_mac_soft_reset |-> mcnt_ff < 4'hF)
      else $error("mac reset too long");
   chk_limit_write: assert property (wr_ok |=> o_backoff_limit_select == $past(i_wr_backoff_limit_select))
      else $error("limit write lost");
   chk_retry_zero: assert property (i_collision && i_retry_count == 5'h0 && !o_mac_soft_reset && !i_cfg_write
      |=> o_backoff_done && !o_backoff_busy) else $error("zero retry did not retry at once");
   chk_done_single: assert property (o_backoff_done && !i_collision |=> !o_backoff_done)
      else $error("done longer than one cycle");
   chk_busy_end: assert property ($fell(o_backoff_busy) && !o_mac_soft_reset && !$past(i_cfg_write)
      |-> o_backoff_done) else $error("busy ended without done");
   chk_slot_whole: assert property (o_backoff_done && $past(o_backoff_busy) |-> bcnt_ff % slot == 0)
      else $error("wait not whole slot times");
endmodule

// ### tb/mbdsc_phy_model.sv
// phy stand-in: divided receive clock and in-band link status
// assumes the mac clock; speed code 0 10m, 1 100m, 2 1000m
module mbdsc_phy_model (
   input wire logic i_ref_clk,
   input wire logic i_link_up,
   input wire logic [1:0] i_speed,
   input wire logic i_full_duplex,
   output logic o_rxc_div,
   output logic o_inband_valid,
   output logic o_inband_full_duplex
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int half;
   assign half = (i_speed == 2'h0) ? 350 : (i_speed == 2'h1) ? 50 : 10;
   initial {o_rxc_div, o_inband_valid, o_inband_full_duplex} = 3'h0;
   // energy-efficient mode is never touched, so no renegotiation is modelled
   always @(negedge i_ref_clk) begin
      cnt <= (cnt + 1) % (2 * half);
      // clock stands still while the link is down
      o_rxc_div <= i_link_up && (cnt >= half);
      o_inband_valid <= i_link_up && (cnt % 16 == 0);
      // status line toggles every cycle between strobes
      o_inband_full_duplex <= (i_link_up && cnt % 16 == 0) ? i_full_duplex : !o_inband_full_duplex;
   end
endmodule

// ### tb/tb_mbdsc_ctrl.sv
// self-checking bench of the back-off, duplex and speed control top
// assumes monitor and phy model compiled first
module tb_mbdsc_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, due1 = 1'b0, due2 = 1'b0;
   logic i_cfg_write, i_wr_duplex_select, i_wr_auto_duplex_detect, i_wr_auto_speed_detect;
   logic i_wr_mac_soft_reset, i_image_load, i_eeprom_present, i_otp_programmed, i_usb_reset;
   logic i_light_soft_reset, i_reset_protect, i_rxc_div, i_inband_valid, i_inband_full_duplex;
   logic i_collision, probe, link, pfd, o_duplex_select, o_auto_duplex_detect, o_auto_speed_detect;
   logic o_mac_soft_reset, o_full_duplex, o_backoff_busy, o_backoff_done;
   logic [1:0] i_wr_speed_select, i_wr_backoff_limit_select, pspd, o_speed_select, o_backoff_limit_select;
   logic [4:0] i_eeprom_image, i_otp_image, i_retry_count;
   logic [8:0] cq[$];
   int bq[$];
   int err_count = 0;
   int tests_run = 0;
   int blen = 0;
   int cyc = 0;
   always #12.5 i_ref_clk = ~i_ref_clk;
   mbdsc_ctrl mbdsc_ctrl_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_write(i_cfg_write),
      .i_wr_duplex_select(i_wr_duplex_select), .i_wr_speed_select(i_wr_speed_select),
      .i_wr_auto_duplex_detect(i_wr_auto_duplex_detect), .i_wr_auto_speed_detect(i_wr_auto_speed_detect),
      .i_wr_backoff_limit_select(i_wr_backoff_limit_select), .i_wr_mac_soft_reset(i_wr_mac_soft_reset),
      .i_image_load(i_image_load), .i_eeprom_present(i_eeprom_present), .i_eeprom_image(i_eeprom_image),
      .i_otp_programmed(i_otp_programmed), .i_otp_image(i_otp_image), .i_usb_reset(i_usb_reset),
      .i_light_soft_reset(i_light_soft_reset), .i_reset_protect(i_reset_protect), .i_rxc_div(i_rxc_div),
      .i_inband_valid(i_inband_valid), .i_inband_full_duplex(i_inband_full_duplex),
      .i_collision(i_collision), .i_retry_count(i_retry_count), .o_duplex_select(o_duplex_select),
      .o_speed_select(o_speed_select), .o_auto_duplex_detect(o_auto_duplex_detect),
      .o_auto_speed_detect(o_auto_speed_detect), .o_backoff_limit_select(o_backoff_limit_select),
      .o_mac_soft_reset(o_mac_soft_reset), .o_full_duplex(o_full_duplex),
      .o_backoff_busy(o_backoff_busy), .o_backoff_done(o_backoff_done));
   mbdsc_phy_model mbdsc_phy_model_i (.i_ref_clk(i_ref_clk), .i_link_up(link), .i_speed(pspd),
      .i_full_duplex(pfd), .o_rxc_div(i_rxc_div), .o_inband_valid(i_inband_valid),
      .o_inband_full_duplex(i_inband_full_duplex));
   task automatic tally_and_finish();
      $display("tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmp_cfg(input logic [8:0] e);
      logic [8:0] g;
      g = {o_mac_soft_reset, o_backoff_limit_select, o_auto_speed_detect, o_auto_duplex_detect,
         o_full_duplex, o_speed_select, o_duplex_select};
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("Error cfg_fields expected %h got %h", e, g);
      end
   endtask
   task automatic cmp_bo(input int len, maxr, slot);
      tests_run++;
      if (len % slot != 0 || len / slot >= maxr) begin
         err_count++;
         $display("Error backoff_cycles expected below %0d slots of %0d got %0d", maxr, slot, len);
      end
   endtask
   // ==========
   // watchers: oldest note against what appears
   always @(posedge i_ref_clk) begin
      int m;
      int s;
      due1 <= i_cfg_write | i_image_load | i_usb_reset | i_light_soft_reset | probe;
      due2 <= due1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         tally_and_finish();
      end
      if (o_backoff_done === 1'b1 && bq.size() > 1) begin
         m = bq.pop_front();
         s = bq.pop_front();
         cmp_bo(blen, m, s);
      end
      blen = (i_collision || o_backoff_busy !== 1'b1) ? 0 : blen + 1;
   end
   always @(negedge i_ref_clk) begin
      if (due2 === 1'b1 && cq.size() > 0) cmp_cfg(cq.pop_front());
   end
   // ==========
   // drivers
   function automatic logic [8:0] ex(input logic mr, input logic [1:0] lim, input logic as, ad,
         input logic [1:0] spd, input logic duplex_select);
      ex = {mr, lim, as, ad, duplex_select | spd[1], spd, duplex_select};
   endfunction
   task automatic go(input logic [8:0] e);
      cq.push_back(e);
      @(negedge i_ref_clk);
      {i_cfg_write, i_image_load, i_usb_reset, i_light_soft_reset, probe} = 5'h0;
      @(negedge i_ref_clk);
   endtask
   // settings change only while the datapath is idle
   task automatic wr(input logic [7:0] v, input logic [8:0] e);
      {i_wr_backoff_limit_select, i_wr_auto_speed_detect, i_wr_auto_duplex_detect,
         i_wr_speed_select, i_wr_duplex_select, i_wr_mac_soft_reset} = v;
      i_cfg_write = 1'b1;
      go(e);
   endtask
   task automatic ld(input logic ep, op, input logic [4:0] ei, oi, input logic [1:0] lim);
      logic [4:0] s;
      s = ep ? ei : op ? oi : 5'h08;
      {i_eeprom_present, i_otp_programmed, i_eeprom_image, i_otp_image} = {ep, op, ei, oi};
      i_image_load = 1'b1;
      // link is down here, so auto fields report the detectors' reset values
      go(ex(1'b0, lim, s[4], s[3], s[4] ? 2'h0 : s[2:1], s[3] ? 1'b0 : s[0]));
   endtask
   task automatic rs(input logic usb, prot, input logic [8:0] e);
      {i_usb_reset, i_light_soft_reset, i_reset_protect} = {usb, !usb, prot};
      go(e);
   endtask
   task automatic collide(input logic [4:0] rt, input int cap, slot);
      bq.push_back(1 << ((rt < cap) ? rt : cap));
      bq.push_back(slot);
      i_retry_count = rt;
      i_collision = 1'b1;
      @(negedge i_ref_clk);
      i_collision = 1'b0;
      for (int n = 0; n < 25000 && o_backoff_done !== 1'b1; n++) @(negedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask
   initial begin
      logic [7:0] v;
      void'($urandom(32'h092F4161));
      {i_cfg_write, i_wr_duplex_select, i_wr_auto_duplex_detect, i_wr_auto_speed_detect} = 4'h0;
      {i_wr_mac_soft_reset, i_image_load, i_eeprom_present, i_otp_programmed, i_usb_reset} = 5'h0;
      {i_light_soft_reset, i_reset_protect, i_collision, probe, link, pfd} = 6'h0;
      {i_wr_speed_select, i_wr_backoff_limit_select, pspd} = 6'h0;
      {i_eeprom_image, i_otp_image, i_retry_count} = 15'h0;
      repeat (4) @(negedge i_ref_clk);
      i_rst = 1'b0;
      probe = 1'b1;
      go(ex(1'b0, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0));
      for (int k = 0; k < 3; k++) ld(k == 0, k < 2, 5'($urandom_range(31)), 5'($urandom_range(31)), 2'h0);
      wr(8'h06, ex(1'b0, 2'h0, 1'b0, 1'b0, 2'h1, 1'b0));
      for (int i = 0; i < 8; i++) begin
         v = {i[2:1], 2'h0, i[1:0], i[2], 1'b0};
         wr(v, ex(1'b0, v[7:6], 1'b0, 1'b0, v[3:2], v[1]));
      end
      ld(1'b0, 1'b1, 5'h00, 5'h05, 2'h3);
      wr(8'hC4, ex(1'b0, 2'h3, 1'b0, 1'b0, 2'h1, 1'b0));
      rs(1'b1, 1'b1, ex(1'b0, 2'h0, 1'b0, 1'b0, 2'h1, 1'b0));
      rs(1'b0, 1'b0, ex(1'b0, 2'h0, 1'b0, 1'b0, 2'h2, 1'b1));
      wr(8'h0B, ex(1'b1, 2'h0, 1'b0, 1'b0, 2'h2, 1'b1));
      repeat (20) @(negedge i_ref_clk);
      probe = 1'b1;
      go(ex(1'b0, 2'h0, 1'b0, 1'b0, 2'h2, 1'b1));
      for (int l = 0; l < 4; l++) begin
         wr({l[1:0], 4'h2, 2'h0}, ex(1'b0, l[1:0], 1'b0, 1'b0, 2'h2, 1'b0));
         collide(5'h00, 10, 21);
         collide(5'($urandom_range(15)), (l == 0) ? 10 : (l == 1) ? 8 : (l == 2) ? 4 : 1, 21);
      end
      for (int p = 0; p < 2; p++) begin
         wr({2'h3, 3'h0, p[0], 2'h0}, ex(1'b0, 2'h3, 1'b0, 1'b0, {1'b0, p[0]}, 1'b0));
         collide(5'h07, 1, p ? 205 : 2048);
      end
      link = 1'b1;
      wr(8'h20, ex(1'b0, 2'h0, 1'b1, 1'b0, 2'h0, 1'b0));
      for (int s = 0; s < 3; s++) begin
         pspd = s[1:0];
         repeat (2200) @(negedge i_ref_clk);
         wr({4'h2, ~s[1:0], 2'h0}, ex(1'b0, 2'h0, 1'b1, 1'b0, s[1:0], 1'b0));
      end
      pspd = 2'h0;
      pfd = 1'b1;
      repeat (2200) @(negedge i_ref_clk);
      wr(8'h20, ex(1'b0, 2'h0, 1'b1, 1'b0, 2'h0, 1'b0));
      repeat (40) @(negedge i_ref_clk);
      wr(8'h30, ex(1'b0, 2'h0, 1'b1, 1'b1, 2'h0, 1'b1));
      pfd = 1'b0;
      repeat (40) @(negedge i_ref_clk);
      probe = 1'b1;
      go(ex(1'b0, 2'h0, 1'b1, 1'b1, 2'h0, 1'b0));
      tally_and_finish();
   end
endmodule
bind mbdsc_ctrl mbdsc_monitor mbdsc_monitor_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_write(i_cfg_write),
   .i_wr_backoff_limit_select(i_wr_backoff_limit_select), .i_wr_mac_soft_reset(i_wr_mac_soft_reset),
   .i_image_load(i_image_load), .i_usb_reset(i_usb_reset), .i_light_soft_reset(i_light_soft_reset),
   .i_collision(i_collision), .i_retry_count(i_retry_count), .o_duplex_select(o_duplex_select),
   .o_speed_select(o_speed_select), .o_backoff_limit_select(o_backoff_limit_select),
   .o_mac_soft_reset(o_mac_soft_reset), .o_full_duplex(o_full_duplex),
   .o_backoff_busy(o_backoff_busy), .o_backoff_done(o_backoff_done));
